// >>> core/gcro_core.sv
// Functional notes
// RULE1: zero-set makes the displayed value zero at the present spindle position.
// RULE2: preset makes the displayed value equal the preset value at present position.
// RULE3: direction bit selects whether spindle motion counts up or down.
// RULE4: modes show current value, maximum, minimum, or runout span (max minus min).
// RULE5: compare against two or four limits, three or five stages, drive judge lines.
// RULE6: displayed value can be produced as decimal digits plus sign.
// RULE7: serial measurement code sends sign and digits nibble-wise on clock/data pins.
// RULE8: serial link host reads values and issues zero, preset, peak-clear commands.
// RULE9: working offset is zero after power-on reset.
// RULE10: first origin mark after reset zeroes the position count automatically.
// RULE11: after origin, display is displacement from origin plus offset.
// RULE12: preset stores preset minus origin-relative position as the offset.
// RULE13: offset kept in retained store, reloaded when origin is acquired.
// RULE14: preset also sets max and min to the current value, runout zero.
// RULE15: peak clear resets peaks in peak modes, acts as preset in current mode.
// RULE16: display is signed count times resolution scale, plus offset, each cycle.
module gcro_core
	import gcro_pkg::*;
#(
	parameter int UART_BIT = UART_BIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic origin_mark,
	input wire logic [31:0] retained_offset,
	output logic retain_wr,
	output logic [31:0] retain_data,
	output logic [JUDGE_W-1:0] judge,
	output logic [4*BCD_DIGITS-1:0] bcd_digits,
	output logic bcd_sign,
	input wire logic spc_req_n,
	output logic spc_clk,
	output logic spc_data,
	input wire logic rs_rxd,
	output logic rs_txd,
	output logic irq
);
	logic [4:0] s1_q, s2_q, prev_q;
	logic [3:0] ctrl_q;
	logic [31:0] preset_q, offset_q, max_q, min_q;
	logic [15:0] scale_q;
	logic [31:0] lim_q [4];
	logic signed [31:0] count_q;
	logic origin_ok_q;
	logic [NEV-1:0] stat_q, en_q, ev;
	logic bcd_sign_q, bcd_busy, bcd_done, bcd_start;
	logic [31:0] rd_d;
	logic wr_acc, cmd_wr;
	gcro_mode_t mode;
	logic signed [31:0] signed_cnt, pos_scaled, cur_val, disp, runout;
	logic quad_up, quad_dn, origin_ev;
	logic u_zero, u_preset, u_pclr, u_read;
	logic do_zero, do_preset, eff_preset, peak_reset;

	// pins from outside: {spc_req_n, rxd, origin, b, a}
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 5'h19;
			s2_q <= 5'h19;
			prev_q <= 5'h19;
		end else begin
			s1_q <= {spc_req_n, rs_rxd, origin_mark, enc_b, enc_a};
			s2_q <= s1_q;
			prev_q <= s2_q;
		end
	end

	always_comb begin
		quad_up = 1'b0;
		quad_dn = 1'b0;
		case ({prev_q[1:0], s2_q[1:0]})
			4'h1, 4'h7, 4'hE, 4'h8: quad_up = 1'b1;
			4'h2, 4'hB, 4'hD, 4'h4: quad_dn = 1'b1;
			default: ;
		endcase
	end
	assign origin_ev = s2_q[2] && !prev_q[2] && !origin_ok_q;

	assign mode = gcro_mode_t'(ctrl_q[CTRL_MODE +: 2]);
	assign signed_cnt = ctrl_q[CTRL_DIR] ? -count_q : count_q; // RULE3
	assign pos_scaled = 32'(signed_cnt * $signed({1'b0, scale_q})); // RULE16
	assign cur_val = pos_scaled + $signed(offset_q); // RULE11 RULE16
	assign runout = $signed(max_q) - $signed(min_q); // RULE4

	always_comb begin
		case (mode) // RULE4
			MODE_MAX: disp = $signed(max_q);
			MODE_MIN: disp = $signed(min_q);
			MODE_RUN: disp = runout;
			default: disp = cur_val;
		endcase
	end

	assign wr_acc = psel && penable && pwrite && pready;
	assign cmd_wr = wr_acc && (paddr == A_CMD);
	assign do_zero = (cmd_wr && pwdata[CMD_ZERO]) || u_zero; // RULE8
	assign do_preset = (cmd_wr && pwdata[CMD_PRESET]) || u_preset;
	assign eff_preset = do_preset || ((cmd_wr && pwdata[CMD_PCLR]) || u_pclr)
		&& (mode == MODE_CUR); // RULE15
	assign peak_reset = eff_preset || do_zero || (cmd_wr && pwdata[CMD_PCLR]) || u_pclr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			origin_ok_q <= 1'b0;
		end else if (origin_ev) begin
			count_q <= '0; // RULE10
			origin_ok_q <= 1'b1;
		end else if (quad_up) begin
			count_q <= count_q + 32'sd1;
		end else if (quad_dn) begin
			count_q <= count_q - 32'sd1;
		end
	end

	// retained store is written on every change so it outlives power-off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_q <= '0; // RULE9
			retain_wr <= 1'b0;
			retain_data <= '0;
		end else begin
			retain_wr <= 1'b0;
			if (origin_ev) begin
				offset_q <= retained_offset; // RULE13
			end else if (eff_preset) begin
				offset_q <= 32'(preset_q - pos_scaled); // RULE2 RULE12
				retain_wr <= 1'b1;
				retain_data <= 32'(preset_q - pos_scaled); // RULE13
			end else if (do_zero) begin
				offset_q <= 32'(-pos_scaled); // RULE1
				retain_wr <= 1'b1;
				retain_data <= 32'(-pos_scaled);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			max_q <= '0;
			min_q <= '0;
		end else if (origin_ev) begin
			max_q <= retained_offset;
			min_q <= retained_offset;
		end else if (eff_preset) begin
			max_q <= preset_q; // RULE14
			min_q <= preset_q;
		end else if (do_zero) begin
			max_q <= '0;
			min_q <= '0;
		end else if (peak_reset) begin
			max_q <= 32'(cur_val); // RULE15
			min_q <= 32'(cur_val);
		end else begin
			if (cur_val > $signed(max_q)) begin
				max_q <= 32'(cur_val);
			end
			if (cur_val < $signed(min_q)) begin
				min_q <= 32'(cur_val);
			end
		end
	end

	// three-stage uses limits 1 and 2 only; stage lines are one-hot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			judge <= '0;
		end else begin
			judge <= '0; // RULE5
			if (ctrl_q[CTRL_FIVE] && disp < $signed(lim_q[0])) begin
				judge[0] <= 1'b1;
			end else if (disp < $signed(lim_q[1])) begin
				judge[1] <= 1'b1;
			end else if (ctrl_q[CTRL_FIVE] && disp > $signed(lim_q[3])) begin
				judge[4] <= 1'b1;
			end else if (disp > $signed(lim_q[2])) begin
				judge[3] <= 1'b1;
			end else begin
				judge[2] <= 1'b1;
			end
		end
	end

	// serial measurement code
	gcro_spc_t sp_q;
	logic [SPC_BITS-1:0] sp_sh_q;
	logic [5:0] sp_bit_q;
	logic [15:0] sp_cnt_q;

	// no restart on the done cycle, else a second conversion and event follow
	assign bcd_start = (cmd_wr && pwdata[CMD_BCD])
		|| (sp_q == SP_CONV && !bcd_busy && !bcd_done); // RULE6
	gcro_bcd #(.W(32), .D(BCD_DIGITS)) u_bcd (
		.pclk(pclk),
		.presetn(presetn),
		.start(bcd_start),
		.mag(disp[31] ? 32'(-disp) : 32'(disp)),
		.busy(bcd_busy),
		.done(bcd_done),
		.digits(bcd_digits)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcd_sign_q <= 1'b0;
		end else if (bcd_start && !bcd_busy) begin
			bcd_sign_q <= disp[31];
		end
	end
	assign bcd_sign = bcd_sign_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= SP_IDLE;
			sp_sh_q <= '0;
			sp_bit_q <= 6'h00;
			sp_cnt_q <= 16'h0000;
			spc_clk <= 1'b1;
			spc_data <= 1'b0;
		end else begin
			case (sp_q) // RULE7
				SP_IDLE: begin
					spc_clk <= 1'b1;
					if (!s2_q[4] && prev_q[4]) begin
						sp_q <= SP_CONV;
					end
				end
				SP_CONV: begin
					if (bcd_done) begin
						sp_sh_q <= {bcd_digits, bcd_sign_q ? SIGN_NEG : SIGN_POS};
						sp_bit_q <= 6'(SPC_BITS);
						sp_cnt_q <= 16'(SPC_HALF_CYC - 1);
						sp_q <= SP_LOW;
					end
				end
				SP_LOW: begin
					spc_clk <= 1'b0;
					spc_data <= sp_sh_q[0];
					if (sp_cnt_q == 16'h0000) begin
						sp_cnt_q <= 16'(SPC_HALF_CYC - 1);
						sp_q <= SP_HIGH;
					end else begin
						sp_cnt_q <= sp_cnt_q - 16'h0001;
					end
				end
				SP_HIGH: begin
					spc_clk <= 1'b1;
					if (sp_cnt_q == 16'h0000) begin
						sp_cnt_q <= 16'(SPC_HALF_CYC - 1);
						sp_sh_q <= {1'b0, sp_sh_q[SPC_BITS-1:1]};
						sp_bit_q <= sp_bit_q - 6'h01;
						sp_q <= (sp_bit_q == 6'h01) ? SP_IDLE : SP_LOW;
					end else begin
						sp_cnt_q <= sp_cnt_q - 16'h0001;
					end
				end
				default: sp_q <= SP_IDLE;
			endcase
		end
	end

	// host serial link, 8N1
	logic rx_busy_q, rx_valid_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic [15:0] rx_cnt_q, tx_cnt_q;
	logic [9:0] tx_fr_q;
	logic [3:0] tx_bit_q;
	logic [2:0] tx_left_q;
	logic [31:0] tx_word_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_cnt_q <= 16'h0000;
		end else begin
			rx_valid_q <= 1'b0;
			if (!rx_busy_q) begin
				if (!s2_q[3]) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= 16'(UART_BIT / 2);
					rx_bit_q <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end else begin
				rx_cnt_q <= 16'(UART_BIT - 1);
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && s2_q[3]) begin
					rx_busy_q <= 1'b0;
				end else if (rx_bit_q == 4'h9) begin
					rx_busy_q <= 1'b0;
					rx_valid_q <= s2_q[3];
				end else if (rx_bit_q != 4'h0) begin
					rx_sh_q <= {s2_q[3], rx_sh_q[7:1]};
				end
			end
		end
	end
	assign u_zero = rx_valid_q && rx_sh_q == UC_ZERO; // RULE8
	assign u_preset = rx_valid_q && rx_sh_q == UC_PRESET;
	assign u_pclr = rx_valid_q && rx_sh_q == UC_PCLR;
	assign u_read = rx_valid_q && rx_sh_q == UC_READ;

	// a read during a reply is dropped: no queue behind the transmitter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fr_q <= 10'h3FF;
			tx_bit_q <= 4'h0;
			tx_left_q <= 3'h0;
			tx_word_q <= '0;
			tx_cnt_q <= 16'h0000;
			rs_txd <= 1'b1;
		end else begin
			if (u_read && tx_left_q == 3'h0 && tx_bit_q == 4'h0) begin
				tx_word_q <= 32'(disp); // RULE8
				tx_left_q <= 3'h4;
			end else if (tx_bit_q == 4'h0 && tx_left_q != 3'h0) begin
				tx_fr_q <= {1'b1, tx_word_q[7:0], 1'b0};
				tx_word_q <= {8'h00, tx_word_q[31:8]};
				tx_left_q <= tx_left_q - 3'h1;
				tx_bit_q <= 4'hA;
				tx_cnt_q <= 16'(UART_BIT - 1);
			end else if (tx_bit_q != 4'h0) begin
				rs_txd <= tx_fr_q[0];
				if (tx_cnt_q == 16'h0000) begin
					tx_cnt_q <= 16'(UART_BIT - 1);
					tx_fr_q <= {1'b1, tx_fr_q[9:1]};
					tx_bit_q <= tx_bit_q - 4'h1;
				end else begin
					tx_cnt_q <= tx_cnt_q - 16'h0001;
				end
			end else begin
				rs_txd <= 1'b1;
			end
		end
	end

	// apb slave: one wait state, writes land with pready
	logic prev_go_q;
	assign ev = {bcd_done, rx_valid_q, judge[2] == 1'b0 && judge != '0 && prev_go_q, origin_ev};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_go_q <= 1'b0;
			stat_q <= '0;
			en_q <= '0;
			irq <= 1'b0;
		end else begin
			prev_go_q <= judge[2];
			stat_q <= (stat_q & ~((wr_acc && paddr == A_CLR) ? pwdata[NEV-1:0] : '0)) | ev;
			if (wr_acc && paddr == A_EN) begin
				en_q <= pwdata[NEV-1:0];
			end
			irq <= |(stat_q & en_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			preset_q <= '0;
			scale_q <= SCALE_RST;
			lim_q <= '{default: '0};
		end else if (wr_acc) begin
			case (paddr)
				A_CTRL: ctrl_q <= pwdata[3:0];
				A_PRESET: preset_q <= pwdata;
				A_SCALE: scale_q <= pwdata[15:0];
				A_LIM0: lim_q[0] <= pwdata;
				A_LIM1: lim_q[1] <= pwdata;
				A_LIM2: lim_q[2] <= pwdata;
				A_LIM3: lim_q[3] <= pwdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (paddr)
			A_CTRL: rd_d = {28'h0000000, ctrl_q};
			A_PRESET: rd_d = preset_q;
			A_SCALE: rd_d = {16'h0000, scale_q};
			A_LIM0: rd_d = lim_q[0];
			A_LIM1: rd_d = lim_q[1];
			A_LIM2: rd_d = lim_q[2];
			A_LIM3: rd_d = lim_q[3];
			A_DISP: rd_d = 32'(disp);
			A_OFFSET: rd_d = offset_q;
			A_STATE: rd_d = {18'h00000, bcd_sign_q, bcd_busy, 5'(judge), 6'h00, origin_ok_q};
			A_BCD_LO: rd_d = bcd_digits[31:0];
			A_BCD_HI: rd_d = {24'h000000, bcd_digits[39:32]};
			A_STAT: rd_d = {28'h0000000, stat_q};
			A_EN: rd_d = {28'h0000000, en_q};
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && (paddr[1:0] != 2'b00 || paddr > A_EN);
			if (psel && penable && !pready && !pwrite) begin
				prdata <= rd_d;
			end else if (psel && penable && !pready && (paddr[1:0] != 2'b00 || paddr > A_EN)) begin
				prdata <= '0;
			end
		end
	end
endmodule

// >>> core/gcro_pkg.sv
package gcro_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_PRESET = 8'h08;
	localparam logic [7:0] A_SCALE = 8'h0C;
	localparam logic [7:0] A_LIM0 = 8'h10;
	localparam logic [7:0] A_LIM1 = 8'h14;
	localparam logic [7:0] A_LIM2 = 8'h18;
	localparam logic [7:0] A_LIM3 = 8'h1C;
	localparam logic [7:0] A_DISP = 8'h20;
	localparam logic [7:0] A_OFFSET = 8'h24;
	localparam logic [7:0] A_STATE = 8'h28;
	localparam logic [7:0] A_BCD_LO = 8'h2C;
	localparam logic [7:0] A_BCD_HI = 8'h30;
	localparam logic [7:0] A_STAT = 8'h34;
	localparam logic [7:0] A_CLR = 8'h38;
	localparam logic [7:0] A_EN = 8'h3C;
	localparam int CTRL_DIR = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_FIVE = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam int CMD_ZERO = 0;
	localparam int CMD_PRESET = 1;
	localparam int CMD_PCLR = 2;
	localparam int CMD_BCD = 3;
	localparam int EV_ORIGIN = 0;
	localparam int EV_NG = 1;
	localparam int EV_RX = 2;
	localparam int EV_BCD = 3;
	localparam int NEV = 4;
	localparam logic [15:0] SCALE_RST = 16'h0001;
	localparam int JUDGE_W = 5;
	localparam int BCD_DIGITS = 10;
	localparam int CLK_MHZ = 250;
	localparam int SPC_HALF_NS = 1000;
	localparam int SPC_HALF_CYC = (SPC_HALF_NS * CLK_MHZ) / 1000;
	localparam int SPC_NIBBLES = 11;
	localparam int SPC_BITS = SPC_NIBBLES * 4;
	localparam int CLK_HZ = 250000000;
	localparam int BAUD = 9600;
	localparam int UART_BIT_CYC = CLK_HZ / BAUD;
	localparam logic [7:0] UC_ZERO = 8'h5A;
	localparam logic [7:0] UC_PRESET = 8'h50;
	localparam logic [7:0] UC_PCLR = 8'h43;
	localparam logic [7:0] UC_READ = 8'h52;
	localparam logic [3:0] SIGN_NEG = 4'h8;
	localparam logic [3:0] SIGN_POS = 4'h0;
	typedef enum logic [1:0] {
		MODE_CUR = 2'b00,
		MODE_MAX = 2'b01,
		MODE_MIN = 2'b10,
		MODE_RUN = 2'b11
	} gcro_mode_t;
	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_CONV = 2'b01,
		SP_LOW = 2'b10,
		SP_HIGH = 2'b11
	} gcro_spc_t;
endpackage

// >>> core/gcro_bcd.sv
module gcro_bcd
	import gcro_pkg::*;
#(
	parameter int W = 32,
	parameter int D = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [W-1:0] mag,
	output logic busy,
	output logic done,
	output logic [4*D-1:0] digits
);
	logic [4*D-1:0] work_q;
	logic [4*D-1:0] adj;
	logic [W-1:0] bin_q;
	logic [7:0] cnt_q;

	// shift-add-3, one bit a cycle: slow but tiny
	always_comb begin
		adj = work_q;
		for (int i = 0; i < D; i++) begin
			if (work_q[4*i +: 4] >= 4'h5) begin
				adj[4*i +: 4] = work_q[4*i +: 4] + 4'h3;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_q <= '0;
			bin_q <= '0;
			cnt_q <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			digits <= '0;
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				work_q <= '0;
				bin_q <= mag;
				cnt_q <= 8'(W);
				busy <= 1'b1;
			end else if (busy) begin
				{work_q, bin_q} <= {adj[4*D-2:0], bin_q, 1'b0};
				cnt_q <= cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
					digits <= {adj[4*D-2:0], bin_q[W-1]};
				end
			end
		end
	end
endmodule

// >>> verification/gcro_core_sva.sv
module gcro_core_sva
	import gcro_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic retain_wr,
	input wire logic [JUDGE_W-1:0] judge,
	input wire logic spc_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_cmd(b);
		s_access ##0 (pwrite && paddr == A_CMD && pwdata[b]);
	endsequence
	a_answer_next: assert property (s_access |=> pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer carries data");
	// first edge after release still shows the reset value
	a_judge_onehot: assert property ($past(presetn) |-> $onehot(judge))
		else $error("judge not one stage");
	a_zero_store: assert property (s_cmd(CMD_ZERO) |-> ##[1:3] retain_wr)
		else $error("zero set not stored");
	a_preset_store: assert property (s_cmd(CMD_PRESET) |-> ##[1:3] retain_wr)
		else $error("preset not stored");
	a_retain_pulse: assert property (retain_wr |=> !retain_wr)
		else $error("store strobe too long");
	a_spc_low_hold: assert property ($fell(spc_clk) |=> !spc_clk [*8])
		else $error("serial clock low too short");
endmodule

// >>> verification/gcro_gage_model.sv
module gcro_gage_model
	import gcro_pkg::*;
(
	input wire logic pclk,
	output logic enc_a,
	output logic enc_b,
	output logic origin_mark,
	output logic [31:0] retained_offset,
	input wire logic retain_wr,
	input wire logic [31:0] retain_data,
	output logic rs_rxd,
	input wire logic rs_txd
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter int STEP_CYC = 4;
	parameter int BIT_CYC = 16;
	int ph = 1;
	// {b,a}; a leads b when moving up
	logic [1:0] ph_tab [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
	// start where the synchronisers reset, so no false step
	initial begin
		enc_a = 1'b1;
		enc_b = 1'b0;
		origin_mark = 1'b0;
		retained_offset = 32'h0;
		rs_rxd = 1'b1;
	end
	// host side of the serial link, 8N1, lsb first
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			rs_rxd <= fr[i];
			repeat (BIT_CYC - 1) @(posedge pclk);
		end
	endtask
	// sample mid-bit; returns in the middle of the stop bit, one bit time after the last data sample
	task automatic get(output logic [7:0] b);
		while (rs_txd !== 1'b0) @(posedge pclk);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			b[i] = rs_txd;
		end
		repeat (BIT_CYC) @(posedge pclk);
	endtask
	// store lives outside the counter, kept over its resets
	always @(posedge pclk) begin
		if (retain_wr) retained_offset <= retain_data;
	end
	task automatic move(input int n);
		repeat (n < 0 ? -n : n) begin
			ph = (ph + (n < 0 ? 3 : 1)) % 4;
			repeat (STEP_CYC) @(posedge pclk);
			{enc_b, enc_a} <= ph_tab[ph];
		end
		repeat (8) @(posedge pclk);
	endtask
	task automatic pass_origin();
		@(posedge pclk);
		origin_mark <= 1'b1;
		repeat (STEP_CYC) @(posedge pclk);
		origin_mark <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule

// >>> verification/gcro_core_tb.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module gcro_core_tb
	import gcro_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, spc_req_n = 1;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv, retained_offset, retain_data;
	logic pready, pslverr, enc_a, enc_b, origin_mark, retain_wr, spc_clk, spc_data;
	logic rs_rxd, rs_txd, irq, bcd_sign, err;
	logic [4:0] judge;
	logic [39:0] bcd_digits;
	int fail_count = 0, n_tests = 0, cyc = 0;
	initial forever #2 pclk = ~pclk;
	gcro_core #(.UART_BIT(16)) gcro_core_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .enc_a, .enc_b, .origin_mark,
		.retained_offset, .retain_wr, .retain_data, .judge, .bcd_digits, .bcd_sign,
		.spc_req_n, .spc_clk, .spc_data, .rs_rxd, .rs_txd, .irq);
	gcro_gage_model gcro_gage_model_i (.pclk, .enc_a, .enc_b, .origin_mark,
		.retained_offset, .retain_wr, .retain_data, .rs_rxd, .rs_txd);
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(0, a, 32'h0);
		`CHK(nm, e, rv)
	endtask
	task automatic t_reset();
		rdc(A_CTRL, 32'h0, "ctrl");
		rdc(A_SCALE, 32'h1, "scale");
		rdc(A_OFFSET, 32'h0, "offset");
		rdc(A_STATE, 32'h200, "state");
		xfer(0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, err)
		wr(A_DISP, 32'h5);
		rdc(A_DISP, 32'h0, "disp");
		$display("reset test done");
	endtask
	task automatic t_count();
		gcro_gage_model_i.move(5);
		rdc(A_DISP, 32'h5, "disp");
		wr(A_SCALE, 32'h3);
		rdc(A_DISP, 32'hF, "disp");
		wr(A_CTRL, 32'h1);
		rdc(A_DISP, 32'hFFFFFFF1, "disp");
		wr(A_CTRL, 32'h0);
		wr(A_SCALE, 32'h1);
		gcro_gage_model_i.move(-5);
		rdc(A_DISP, 32'h0, "disp");
		$display("count test done");
	endtask
	task automatic t_origin();
		wr(A_EN, 32'h1);
		gcro_gage_model_i.pass_origin();
		`CHK("irq", 1'b1, irq)
		rdc(A_STATE, 32'h201, "state");
		wr(A_CLR, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK("irq", 1'b0, irq)
		gcro_gage_model_i.move(4);
		rdc(A_DISP, 32'h4, "disp");
		$display("origin test done");
	endtask
	task automatic t_preset();
		wr(A_PRESET, 32'hC);
		wr(A_CMD, 32'h2);
		rdc(A_DISP, 32'hC, "disp");
		rdc(A_OFFSET, 32'h8, "offset");
		`CHK("store", 32'h8, retained_offset)
		gcro_gage_model_i.move(-3);
		wr(A_CTRL, 32'h2);
		rdc(A_DISP, 32'hC, "max");
		wr(A_CTRL, 32'h4);
		rdc(A_DISP, 32'h9, "min");
		wr(A_CTRL, 32'h6);
		rdc(A_DISP, 32'h3, "runout");
		wr(A_CTRL, 32'h0);
		wr(A_CMD, 32'h2);
		wr(A_CTRL, 32'h6);
		rdc(A_DISP, 32'h0, "runout");
		gcro_gage_model_i.move(-2);
		rdc(A_DISP, 32'h2, "runout");
		wr(A_CMD, 32'h4);
		rdc(A_DISP, 32'h0, "runout");
		wr(A_CTRL, 32'h0);
		rdc(A_DISP, 32'hA, "disp");
		wr(A_PRESET, 32'h14);
		wr(A_CMD, 32'h4);
		rdc(A_DISP, 32'h14, "disp");
		$display("preset test done");
	endtask
	task automatic t_zero();
		wr(A_CMD, 32'h1);
		rdc(A_DISP, 32'h0, "disp");
		gcro_gage_model_i.move(1);
		rdc(A_DISP, 32'h1, "disp");
		@(posedge pclk);
		presetn <= 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
		rdc(A_OFFSET, 32'h0, "offset");
		gcro_gage_model_i.pass_origin();
		rdc(A_DISP, 32'h1, "disp");
		$display("zero test done");
	endtask
	task automatic t_judge();
		wr(A_PRESET, 32'h14);
		wr(A_CMD, 32'h2);
		wr(A_LIM1, 32'hFFFFFFF6);
		wr(A_LIM2, 32'hA);
		wr(A_EN, 32'h2);
		// judge and irq lag a landed write by one edge
		repeat (2) @(posedge pclk);
		`CHK("judge", 5'b01000, judge)
		`CHK("irq", 1'b1, irq)
		wr(A_CTRL, 32'h8);
		wr(A_LIM3, 32'hF);
		wr(A_LIM0, 32'hFFFFFFEC);
		`CHK("judge", 5'b10000, judge)
		wr(A_PRESET, 32'hFFFFFFF4);
		wr(A_CMD, 32'h2);
		repeat (2) @(posedge pclk);
		`CHK("judge", 5'b00010, judge)
		wr(A_PRESET, 32'h0);
		wr(A_CMD, 32'h2);
		repeat (2) @(posedge pclk);
		`CHK("judge", 5'b00100, judge)
		wr(A_CLR, 32'h2);
		repeat (2) @(posedge pclk);
		`CHK("irq", 1'b0, irq)
		$display("judge test done");
	endtask
	task automatic t_bcd();
		int n;
		wr(A_PRESET, 32'hFFFFFB2E);
		wr(A_CMD, 32'h2);
		wr(A_CMD, 32'h8);
		rv = 32'h0;
		for (n = 0; n < 30 && rv[3] !== 1'b1; n++) xfer(0, A_STAT, 32'h0);
		`CHK("digits", 40'h1234, bcd_digits)
		`CHK("sign", 1'b1, bcd_sign)
		$display("bcd test done");
	endtask
	task automatic t_spc();
		logic [7:0] v;
		@(posedge pclk);
		spc_req_n <= 0;
		repeat (8) @(posedge pclk);
		spc_req_n <= 1;
		for (int i = 0; i < 8; i++) begin
			while (spc_clk !== 1'b0) @(posedge pclk);
			while (spc_clk !== 1'b1) @(posedge pclk);
			v[i] = spc_data;
		end
		`CHK("serial", 8'h48, v)
		$display("serial code test done");
	endtask
	task automatic t_host();
		logic [7:0] b;
		logic [31:0] w;
		wr(A_EN, 32'h4);
		gcro_gage_model_i.send(UC_READ);
		for (int i = 0; i < 4; i++) begin
			gcro_gage_model_i.get(b);
			w[8*i +: 8] = b;
		end
		`CHK("reply", 32'hFFFFFB2E, w)
		`CHK("irq", 1'b1, irq)
		gcro_gage_model_i.send(UC_ZERO);
		rdc(A_DISP, 32'h0, "disp");
		gcro_gage_model_i.send(UC_PRESET);
		rdc(A_DISP, 32'hFFFFFB2E, "disp");
		$display("host test done");
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
		t_reset();
		t_count();
		t_origin();
		t_preset();
		t_zero();
		t_judge();
		t_bcd();
		t_spc();
		t_host();
		summarize();
	end
endmodule
bind gcro_core gcro_core_sva gcro_core_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .retain_wr, .judge, .spc_clk);
